//--- rtl/vid_cap_pkg.sv
/*
 constants for the video input capture and vertical scaler setup block.
 assumes one core clock domain; pixel clock and pixel bus arrive from outside.
*/
package vid_cap_pkg;
    localparam int BUS_W = 12;
    localparam int PAR_W = 12;
    localparam logic [11:0] PAR_MAX = 12'hFFF;
    localparam logic [12:0] WEIGHT_HALF = 13'h0800;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_VOFS = 8'h04;
    localparam logic [7:0] OFS_VOFSE = 8'h08;
    localparam logic [7:0] OFS_SKIP = 8'h0C;
    localparam logic [7:0] OFS_VINC = 8'h10;
    localparam logic [7:0] OFS_WGTO = 8'h14;
    localparam logic [7:0] OFS_WGTE = 8'h18;
    localparam logic [7:0] OFS_GAIN = 8'h1C;
    localparam logic [7:0] OFS_STAT = 8'h20;
    localparam logic [7:0] OFS_PIX = 8'h24;
    // control bit positions
    localparam int CTL_EDGE = 0;
    localparam int CTL_SLOT = 1;
    localparam int CTL_FMT = 2;
    localparam int CTL_UPSC = 3;
    localparam int CTL_FAST = 4;
    localparam int CTL_FULL = 5;
    localparam int CTL_SETUP = 6;
    localparam int CTL_FILT = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [7:0] GAIN_RST = 8'h80;
    localparam logic [7:0] LUMA_GAIN_SETUP = 8'h76;
    localparam logic [7:0] LUMA_GAIN_NOSETUP = 8'h80;
    localparam logic [7:0] FULL_SCALE_GAIN = 8'h6E;
    typedef enum logic [2:0] {
        CAP_IDLE = 3'b001,
        CAP_HALF = 3'b010,
        CAP_DONE = 3'b100
    } cap_state_t;
endpackage

//--- rtl/vid_cap.sv
/*
 pixel capture on both pixel clock edges plus vertical scaler setup registers.
 assumes a register master on i_core_clk and a pixel clock far slower than it.
*/
// Design decisions made here: the plain strobed port and the placing of the registers.
//
// Contract
// - skip 0 max filtering, 4095 none
// - zero increment means factor one
// - doubling bit halves effective increment
// - filter select ignored while doubling
// - studio levels, optional full swing gain
// - chroma gains free, luma gain predefined
// - separate luma and colour difference gains
// - fast input cells bit resets to 0
// - edge and slot bits order halves
// - 24-bit format bit placement
// - 15-bit format bit placement
`timescale 1ns/1ps
module vid_cap (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_pix_clk,
    input wire logic [11:0] i_pix_data,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic [23:0] o_pixel,
    output logic o_pixel_valid,
    output logic o_fast_input_cells,
    output logic [12:0] o_eff_increment,
    output logic o_filter_enable,
    output logic [1:0] o_vertical_filter_select,
    output logic [7:0] o_luma_gain,
    output logic [7:0] o_cb_gain,
    output logic [7:0] o_cr_gain
);
    logic [31:0] ctrl_ff;
    logic [11:0] vertical_input_offset_ff;
    logic [11:0] even_field_vertical_offset_ff;
    logic [11:0] antiflicker_skip_ff;
    logic [11:0] vertical_increment_ff;
    logic [12:0] odd_initial_weight_ff;
    logic [12:0] even_initial_weight_ff;
    logic [7:0] cb_gain_ff;
    logic [7:0] cr_gain_ff;
    logic [7:0] rgb_luma_gain_ff;
    logic [7:0] rgb_cd_gain_ff;
    logic [1:0] pclk_sync_ff;
    logic [11:0] pd_meta_ff;
    logic [11:0] pd_sync_ff;
    logic pclk_prev_ff;
    logic [11:0] first_half_ff;
    logic [23:0] pixel_ff;
    logic valid_ff;
    logic [7:0] pix_count_ff;
    logic weight_zero_err_ff;
    vid_cap_pkg::cap_state_t state_ff;
    vid_cap_pkg::cap_state_t nxt_state;
    logic rise_evt;
    logic fall_evt;
    logic first_evt;
    logic second_evt;
    logic [23:0] nxt_pixel;

    // the packing function is written for a 12-bit bus only
    if (vid_cap_pkg::BUS_W != 12) begin : g_bus_chk
        $error("pixel bus must be 12 bits");
    end

    // register writes
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_ff <= vid_cap_pkg::CTRL_RST;
            vertical_input_offset_ff <= '0;
            even_field_vertical_offset_ff <= '0;
            antiflicker_skip_ff <= '0;
            vertical_increment_ff <= '0;
            odd_initial_weight_ff <= vid_cap_pkg::WEIGHT_HALF;
            even_initial_weight_ff <= vid_cap_pkg::WEIGHT_HALF;
            cb_gain_ff <= vid_cap_pkg::GAIN_RST;
            cr_gain_ff <= vid_cap_pkg::GAIN_RST;
            rgb_luma_gain_ff <= vid_cap_pkg::GAIN_RST;
            rgb_cd_gain_ff <= vid_cap_pkg::GAIN_RST;
        end else if (i_ce && i_wr) begin
            case (i_addr)
                vid_cap_pkg::OFS_CTRL: ctrl_ff <= {22'h0, i_wdata[9:0]};
                vid_cap_pkg::OFS_VOFS: vertical_input_offset_ff <= i_wdata[11:0];
                vid_cap_pkg::OFS_VOFSE: even_field_vertical_offset_ff <= i_wdata[11:0];
                vid_cap_pkg::OFS_SKIP: antiflicker_skip_ff <= i_wdata[11:0];
                vid_cap_pkg::OFS_VINC: vertical_increment_ff <= i_wdata[11:0];
                vid_cap_pkg::OFS_WGTO: odd_initial_weight_ff <= i_wdata[12:0];
                vid_cap_pkg::OFS_WGTE: even_initial_weight_ff <= i_wdata[12:0];
                vid_cap_pkg::OFS_GAIN: begin
                    cb_gain_ff <= i_wdata[7:0];
                    cr_gain_ff <= i_wdata[15:8];
                    rgb_luma_gain_ff <= i_wdata[23:16];
                    rgb_cd_gain_ff <= i_wdata[31:24];
                end
                default: begin
                end
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= '0;
        end else if (i_ce) begin
            if (i_rd) begin
                case (i_addr)
                    vid_cap_pkg::OFS_CTRL: o_rdata <= ctrl_ff;
                    vid_cap_pkg::OFS_VOFS: o_rdata <= {20'h0, vertical_input_offset_ff};
                    vid_cap_pkg::OFS_VOFSE: o_rdata <= {20'h0, even_field_vertical_offset_ff};
                    vid_cap_pkg::OFS_SKIP: o_rdata <= {20'h0, antiflicker_skip_ff};
                    vid_cap_pkg::OFS_VINC: o_rdata <= {20'h0, vertical_increment_ff};
                    vid_cap_pkg::OFS_WGTO: o_rdata <= {19'h0, odd_initial_weight_ff};
                    vid_cap_pkg::OFS_WGTE: o_rdata <= {19'h0, even_initial_weight_ff};
                    vid_cap_pkg::OFS_GAIN: o_rdata <= {rgb_cd_gain_ff, rgb_luma_gain_ff, cr_gain_ff, cb_gain_ff};
                    vid_cap_pkg::OFS_STAT: o_rdata <= {23'h0, weight_zero_err_ff, state_ff, 5'h0};
                    vid_cap_pkg::OFS_PIX: o_rdata <= {pix_count_ff, pixel_ff};
                    default: o_rdata <= '0;
                endcase
            end else begin
                o_rdata <= '0;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            weight_zero_err_ff <= 1'b0;
        end else if (i_ce) begin
            weight_zero_err_ff <= (vertical_increment_ff == 12'h000)
                && (odd_initial_weight_ff == 13'h0000 || even_initial_weight_ff == 13'h0000);
        end
    end

    always_comb begin
        if (vertical_increment_ff == 12'h000) begin
            o_eff_increment = 13'h1000;
        end else if (ctrl_ff[vid_cap_pkg::CTL_UPSC]) begin
            o_eff_increment = {2'b00, vertical_increment_ff[11:1]};
        end else begin
            o_eff_increment = {1'b0, vertical_increment_ff};
        end
    end

    assign o_filter_enable = !ctrl_ff[vid_cap_pkg::CTL_UPSC];
    assign o_vertical_filter_select = ctrl_ff[vid_cap_pkg::CTL_UPSC] ? 2'b00 : ctrl_ff[9:8];
    assign o_fast_input_cells = ctrl_ff[vid_cap_pkg::CTL_FAST];
    always_comb begin
        if (ctrl_ff[vid_cap_pkg::CTL_FULL]) begin
            o_luma_gain = vid_cap_pkg::FULL_SCALE_GAIN;
        end else if (ctrl_ff[vid_cap_pkg::CTL_SETUP]) begin
            o_luma_gain = vid_cap_pkg::LUMA_GAIN_SETUP;
        end else begin
            o_luma_gain = vid_cap_pkg::LUMA_GAIN_NOSETUP;
        end
    end
    assign o_cb_gain = ctrl_ff[vid_cap_pkg::CTL_FULL] ? rgb_cd_gain_ff : cb_gain_ff;
    assign o_cr_gain = ctrl_ff[vid_cap_pkg::CTL_FULL] ? rgb_luma_gain_ff : cr_gain_ff;

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pclk_sync_ff <= 2'b00;
            pd_meta_ff <= '0;
            pd_sync_ff <= '0;
            pclk_prev_ff <= 1'b0;
        end else if (i_ce) begin
            pclk_sync_ff <= {pclk_sync_ff[0], i_pix_clk};
            pd_meta_ff <= i_pix_data;
            pd_sync_ff <= pd_meta_ff;
            pclk_prev_ff <= pclk_sync_ff[1];
        end
    end

    assign rise_evt = pclk_sync_ff[1] && !pclk_prev_ff;
    assign fall_evt = !pclk_sync_ff[1] && pclk_prev_ff;
    assign first_evt = ctrl_ff[vid_cap_pkg::CTL_EDGE] ? fall_evt : rise_evt;
    assign second_evt = ctrl_ff[vid_cap_pkg::CTL_EDGE] ? rise_evt : fall_evt;

    function automatic logic [23:0] pack_pixel(input logic [11:0] gb, input logic [11:0] rg,
                                               input logic fmt15);
        logic [23:0] p;
        p = '0;
        if (fmt15) begin
            p[23:19] = rg[6:2];
            p[15:11] = {rg[1:0], gb[7:5]};
            p[7:3] = gb[4:0];
        end else begin
            p[23:16] = rg[11:4];
            p[15:8] = {rg[3:0], gb[11:8]};
            p[7:0] = gb[7:0];
        end
        return p;
    endfunction

    assign nxt_pixel = ctrl_ff[vid_cap_pkg::CTL_SLOT]
        ? pack_pixel(pd_sync_ff, first_half_ff, ctrl_ff[vid_cap_pkg::CTL_FMT])
        : pack_pixel(first_half_ff, pd_sync_ff, ctrl_ff[vid_cap_pkg::CTL_FMT]);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            vid_cap_pkg::CAP_IDLE: if (first_evt) nxt_state = vid_cap_pkg::CAP_HALF;
            vid_cap_pkg::CAP_HALF: if (second_evt) nxt_state = vid_cap_pkg::CAP_DONE;
            vid_cap_pkg::CAP_DONE: nxt_state = first_evt ? vid_cap_pkg::CAP_HALF : vid_cap_pkg::CAP_IDLE;
            default: nxt_state = vid_cap_pkg::CAP_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_ff <= vid_cap_pkg::CAP_IDLE;
            first_half_ff <= '0;
            pixel_ff <= '0;
            valid_ff <= 1'b0;
            pix_count_ff <= '0;
        end else if (i_ce) begin
            state_ff <= nxt_state;
            valid_ff <= 1'b0;
            if (first_evt) begin
                first_half_ff <= pd_sync_ff;
            end
            if (state_ff == vid_cap_pkg::CAP_HALF && second_evt) begin
                pixel_ff <= nxt_pixel;
                valid_ff <= 1'b1;
                pix_count_ff <= pix_count_ff + 8'h01;
            end
        end
    end

    assign o_pixel = pixel_ff;
    assign o_pixel_valid = valid_ff;

    // assertions
    sequence half_seen_s;
        state_ff == vid_cap_pkg::CAP_HALF && second_evt && i_ce;
    endsequence

    // the 15-bit format leaves the low bits of every colour empty
    sequence fmt15_half_s;
        half_seen_s ##0 ctrl_ff[vid_cap_pkg::CTL_FMT];
    endsequence

    pixel_done_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        half_seen_s |=> o_pixel_valid && state_ff == vid_cap_pkg::CAP_DONE)
        else $error("pixel not completed after second half");
    valid_cause_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_pixel_valid |-> $past(state_ff) == vid_cap_pkg::CAP_HALF)
        else $error("pixel valid without captured half");
    filter_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        ctrl_ff[vid_cap_pkg::CTL_UPSC] |-> !o_filter_enable && o_vertical_filter_select == 2'b00)
        else $error("filter active in doubling mode");
    double_inc_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        ctrl_ff[vid_cap_pkg::CTL_UPSC] && vertical_increment_ff != 12'h000
        |-> o_eff_increment == {2'b00, vertical_increment_ff[11:1]})
        else $error("doubling increment wrong");
    unity_inc_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        vertical_increment_ff == 12'h000 |-> o_eff_increment == 13'h1000)
        else $error("zero increment not unity");
    fast_reset_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        $rose(i_rst_b) |-> !o_fast_input_cells)
        else $error("fast cells not cleared by reset");
    order_edge_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        first_evt && i_ce |=> first_half_ff == $past(pd_sync_ff))
        else $error("first half not captured on selected edge");
    pack24_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (half_seen_s and (!ctrl_ff[vid_cap_pkg::CTL_FMT] && !ctrl_ff[vid_cap_pkg::CTL_SLOT]))
        |=> o_pixel[7:0] == $past(first_half_ff[7:0]) && o_pixel[23:16] == $past(pd_sync_ff[11:4]))
        else $error("24-bit packing wrong");
    pack15_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        fmt15_half_s |=> o_pixel[2:0] == 3'h0 && o_pixel[18:16] == 3'h0)
        else $error("15-bit packing set unused bits");
    skip_store_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_ce && i_wr && i_addr == vid_cap_pkg::OFS_SKIP |=> antiflicker_skip_ff == $past(i_wdata[11:0]))
        else $error("skip value not stored");
    luma_setup_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !ctrl_ff[vid_cap_pkg::CTL_FULL] && ctrl_ff[vid_cap_pkg::CTL_SETUP]
        |-> o_luma_gain == vid_cap_pkg::LUMA_GAIN_SETUP)
        else $error("luma gain not predefined for setup");

    // gain and filter outputs follow the control bits with no delay
    full_gain_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        ctrl_ff[vid_cap_pkg::CTL_FULL] |-> o_luma_gain == vid_cap_pkg::FULL_SCALE_GAIN)
        else $error("full swing gain not applied");
    luma_plain_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !ctrl_ff[vid_cap_pkg::CTL_FULL] && !ctrl_ff[vid_cap_pkg::CTL_SETUP]
        |-> o_luma_gain == vid_cap_pkg::LUMA_GAIN_NOSETUP)
        else $error("luma gain not predefined without setup");
    chroma_gain_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !ctrl_ff[vid_cap_pkg::CTL_FULL] |-> o_cb_gain == cb_gain_ff && o_cr_gain == cr_gain_ff)
        else $error("chroma gains not independent");
    rgb_gain_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        ctrl_ff[vid_cap_pkg::CTL_FULL] |-> o_cb_gain == rgb_cd_gain_ff && o_cr_gain == rgb_luma_gain_ff)
        else $error("rgb path gains not separate");
    filter_pass_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !ctrl_ff[vid_cap_pkg::CTL_UPSC] |-> o_filter_enable && o_vertical_filter_select == ctrl_ff[9:8])
        else $error("filter select lost outside doubling");
    plain_inc_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !ctrl_ff[vid_cap_pkg::CTL_UPSC] && vertical_increment_ff != 12'h000
        |-> o_eff_increment == {1'b0, vertical_increment_ff})
        else $error("increment changed outside doubling");
    zero_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_ce && vertical_increment_ff == 12'h000 && odd_initial_weight_ff == 13'h0000 |=> weight_zero_err_ff)
        else $error("zero weight not flagged");

    // pixel packing; each field comes from the half that carries it
    slot_swap_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (half_seen_s and (!ctrl_ff[vid_cap_pkg::CTL_FMT] && ctrl_ff[vid_cap_pkg::CTL_SLOT]))
        |=> o_pixel[7:0] == $past(pd_sync_ff[7:0]) && o_pixel[23:16] == $past(first_half_ff[11:4]))
        else $error("slot order not applied");
    pack15_fields_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (fmt15_half_s ##0 !ctrl_ff[vid_cap_pkg::CTL_SLOT])
        |=> o_pixel[23:19] == $past(pd_sync_ff[6:2]) && o_pixel[7:3] == $past(first_half_ff[4:0]))
        else $error("15-bit fields misplaced");
    unused_bits_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        fmt15_half_s |=> o_pixel[10:8] == 3'h0)
        else $error("unused bus bits reached the pixel");
    pixel_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !o_pixel_valid |-> $stable(o_pixel))
        else $error("pixel changed without valid");
endmodule

//--- bench/vid_gfx_model.sv
/*
 behavioural graphics controller: drives the pixel clock and the 12-bit pixel bus.
 assumes the bench calls park and send, and that the capture side samples the bus
 with the core clock, so data stay put 8 ns either side of every pixel clock edge.
*/
`timescale 1ns/1ps
module vid_gfx_model (
    output logic o_pix_clk,
    output logic [11:0] o_pix_data
);
    initial begin
        o_pix_clk = 1'b0;
        o_pix_data = 12'h000;
    end

    // clock stands still between frames at the level that makes the next edge the first-half edge
    // one nanosecond off the core edges, so no pin change races a sampling edge
    task automatic park(input logic lvl);
        #9 o_pix_clk = lvl;
        #8 o_pix_data = ~o_pix_data;
    endtask

    task automatic send(input logic [23:0] px, input logic edge_b, input logic slot_b, input logic fmt15);
        logic [11:0] gb;
        logic [11:0] rh;
        logic [31:0] rnd;
        rnd = $urandom;
        gb = {px[11:8], px[7:0]};
        rh = {px[23:16], px[15:12]};
        // 15-bit halves, unused bits carry junk
        if (fmt15) begin
            gb = {rnd[3:0], px[13:11], px[7:3]};
            rh = {rnd[7:4], rnd[8], px[23:19], px[15:14]};
        end
        // slot picks the first half, edge level picks the first edge
        #8 o_pix_data = slot_b ? rh : gb;
        #8 o_pix_clk = ~edge_b;
        #8 o_pix_data = slot_b ? gb : rh;
        // next call moves the bus 8 ns later, keeping a 32 ns clock period
        #8 o_pix_clk = edge_b;
    endtask
endmodule

//--- bench/video_input_capture_vertical_scaler_tb_top.sv
/*
 self-checking bench for the capture and vertical scaler setup block.
 assumes vid_cap with its package and the graphics controller model beside it.
*/
`timescale 1ns/1ps
module video_input_capture_vertical_scaler_tb_top;
    logic i_core_clk, i_rst_b, i_ce, i_wr, i_rd;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, rd, c;
    logic pix_clk;
    logic [11:0] pix_data;
    logic [23:0] o_pixel, px;
    logic o_pixel_valid, o_fast_input_cells, o_filter_enable;
    logic [12:0] o_eff_increment;
    logic [1:0] o_vertical_filter_select;
    logic [7:0] o_luma_gain, o_cb_gain, o_cr_gain;
    int failures, n_tests, cycles;
    longint skip, inc_l, wgte, ofs, eofs;
    logic [23:0] exp_q[$];
    logic [31:0] mdl[8];

    vid_cap vid_cap_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_pix_clk(pix_clk),
        .i_pix_data(pix_data), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_pixel(o_pixel), .o_pixel_valid(o_pixel_valid),
        .o_fast_input_cells(o_fast_input_cells), .o_eff_increment(o_eff_increment),
        .o_filter_enable(o_filter_enable), .o_vertical_filter_select(o_vertical_filter_select),
        .o_luma_gain(o_luma_gain), .o_cb_gain(o_cb_gain), .o_cr_gain(o_cr_gain));
    vid_gfx_model vid_gfx_model_inst (.o_pix_clk(pix_clk), .o_pix_data(pix_data));

    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pix(input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected pixel expected %h seen %h", exp, got);
        end
    endtask

    // model follows only mapped writes taken with the enable high
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        if (i_ce === 1'b1 && a <= vid_cap_pkg::OFS_GAIN)
            mdl[a >> 2] = d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic check_outs();
        logic [12:0] inc;
        inc = mdl[4][12:0];
        @(posedge i_core_clk);
        #1;
        chk_val("fast cells", mdl[0][4], o_fast_input_cells);
        chk_val("eff increment", inc == 0 ? 13'h1000 : (mdl[0][3] ? inc >> 1 : inc), o_eff_increment);
        chk_val("filter enable", !mdl[0][3], o_filter_enable);
        chk_val("filter select", mdl[0][3] ? 2'b00 : mdl[0][9:8], o_vertical_filter_select);
        chk_val("luma gain", mdl[0][5] ? vid_cap_pkg::FULL_SCALE_GAIN : (mdl[0][6] ? vid_cap_pkg::LUMA_GAIN_SETUP
            : vid_cap_pkg::LUMA_GAIN_NOSETUP), o_luma_gain);
        chk_val("cb gain", mdl[0][5] ? mdl[7][31:24] : mdl[7][7:0], o_cb_gain);
        chk_val("cr gain", mdl[0][5] ? mdl[7][23:16] : mdl[7][15:8], o_cr_gain);
    endtask

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("unexpected timeout after %0d cycles", cycles);
            give_verdict();
        end
        if (i_rst_b === 1'b1 && o_pixel_valid === 1'b1) begin
            if (exp_q.size() > 0)
                chk_pix(exp_q.pop_front(), o_pixel);
            else
                chk_val("spurious pixel", 0, 1);
        end
    end

    initial begin
        i_rst_b = 1'b0; i_ce = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_addr = 8'h00; i_wdata = 32'h0;
        failures = 0; n_tests = 0; cycles = 0;
        void'($urandom(32'h8591814d));
        foreach (mdl[k]) mdl[k] = 32'h0;
        mdl[5] = 32'(vid_cap_pkg::WEIGHT_HALF);
        mdl[6] = 32'(vid_cap_pkg::WEIGHT_HALF);
        mdl[7] = {4{vid_cap_pkg::GAIN_RST}};
        repeat (8) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        foreach (mdl[k]) if (k == 0 || k >= 5) begin
            reg_rd(8'(k * 4), rd);
            chk_val("reset value", mdl[k], rd);
        end
        // skip of zero and plain read-back of the scaler fields
        reg_wr(vid_cap_pkg::OFS_SKIP, 32'h0);
        reg_rd(vid_cap_pkg::OFS_SKIP, rd);
        chk_val("skip", mdl[3], rd);
        for (int t = 0; t < 8; t++) begin
            c = (t == 0) ? 32'hFFF : 32'($urandom_range(4095, 0));
            reg_wr(8'(4 + 4 * (t % 6)), c);
            reg_rd(8'(4 + 4 * (t % 6)), rd);
            chk_val("scaler reg", mdl[1 + t % 6], rd);
        end
        // every doubling, full swing and setup combination, zero increment first
        for (int t = 0; t < 10; t++) begin
            c = $urandom & 32'h317;
            c[3] = t[0];
            c[5] = t[1];
            c[6] = t[2];
            reg_wr(vid_cap_pkg::OFS_CTRL, c);
            reg_wr(vid_cap_pkg::OFS_VINC, t < 2 ? 32'h0 : 32'($urandom_range(4095, 1)));
            reg_wr(vid_cap_pkg::OFS_GAIN, $urandom);
            check_outs();
            reg_rd(vid_cap_pkg::OFS_CTRL, rd);
            chk_val("ctrl", mdl[0], rd);
        end
        // zero weight with zero increment is flagged
        reg_wr(vid_cap_pkg::OFS_VINC, 32'h0);
        reg_wr(vid_cap_pkg::OFS_WGTO, 32'h0);
        reg_rd(vid_cap_pkg::OFS_STAT, rd);
        chk_val("zero weight flag", 1, rd[8]);
        reg_wr(vid_cap_pkg::OFS_WGTO, 32'h800);
        reg_rd(vid_cap_pkg::OFS_STAT, rd);
        chk_val("zero weight flag", 32'(mdl[6][12:0] == 13'h0), rd[8]);
        // software increment, skip lowered until it fits
        skip = 4095;
        inc_l = 240 * (4095 + skip) * 4096 / (402 * 4095);
        while (inc_l > 4095) begin
            skip--;
            inc_l = 240 * (4095 + skip) * 4096 / (402 * 4095);
        end
        // offset from first active line, rounded down, both fields alike
        ofs = (19 * 1716 * 37037 * 2 - 5 * 800 * 40000) / (2 * 800 * 40000);
        eofs = ofs;
        // non-interlaced input, even weight wrapped by the increment
        wgte = (inc_l - skip) / 2;
        while (wgte < 0) begin
            wgte += inc_l;
            eofs++;
        end
        reg_wr(vid_cap_pkg::OFS_VOFS, 32'(ofs));
        reg_wr(vid_cap_pkg::OFS_VOFSE, 32'(eofs));
        reg_wr(vid_cap_pkg::OFS_SKIP, 32'(skip));
        reg_wr(vid_cap_pkg::OFS_VINC, 32'(inc_l));
        reg_wr(vid_cap_pkg::OFS_WGTO, 32'(inc_l / 2 + 2048));
        reg_wr(vid_cap_pkg::OFS_WGTE, 32'(wgte));
        for (int k = 1; k < 7; k++) begin
            reg_rd(8'(k * 4), rd);
            chk_val("scaler setup", mdl[k], rd);
        end
        check_outs();
        // unmapped place and frozen enable
        reg_wr(8'h40, $urandom);
        reg_rd(8'h40, rd);
        chk_val("unmapped read", 0, rd);
        @(posedge i_core_clk);
        i_ce <= 1'b0;
        reg_wr(vid_cap_pkg::OFS_SKIP, 32'h5A5);
        @(posedge i_core_clk);
        i_ce <= 1'b1;
        reg_rd(vid_cap_pkg::OFS_SKIP, rd);
        chk_val("frozen write", mdl[3], rd);
        // all edge, slot and format combinations, three pixels back to back each
        for (int m = 0; m < 8; m++) begin
            c = mdl[0];
            c[0] = m[0];
            c[1] = m[1];
            c[2] = m[2];
            // doubling off: the short gaps here are no long line blanking
            c[3] = 1'b0;
            reg_wr(vid_cap_pkg::OFS_CTRL, c);
            vid_gfx_model_inst.park(c[0]);
            repeat (3) begin
                px = 24'($urandom);
                if (c[2])
                    px = px & 24'hF8F8F8;
                exp_q.push_back(px);
                vid_gfx_model_inst.send(px, c[0], c[1], c[2]);
            end
            for (int w = 0; w < 100 && exp_q.size() > 0; w++)
                @(posedge i_core_clk);
            chk_val("pixels missing", 0, exp_q.size());
            reg_rd(vid_cap_pkg::OFS_PIX, rd);
            chk_val("pixel count", {8'(3 * (m + 1)), px}, rd);
            check_outs();
        end
        c = mdl[0];
        c[4] = 1'b0;
        reg_wr(vid_cap_pkg::OFS_CTRL, c);
        check_outs();
        give_verdict();
    end
endmodule
